// *** logic/osc_clock_switch_watchdog.sv ***
// Clock source selection, oscillator control, halts and watchdog behind an AHB-Lite slave
// How it works
// RULE_01: Switch first, disable old oscillator later.
// RULE_02: 0x36 selects high RC, low RC on.
// RULE_03: 0xA6 selects crystal, low RC on.
// RULE_04: 0x50 kills old source, processor hangs.
// RULE_05: No crystal check; unstable crystal hangs.
// RULE_06: Software waits after crystal enable.
// RULE_07: Crystal bits 6:5 pick drive range.
// RULE_08: Crystal bit 7 enables crystal oscillator.
// RULE_09: Software sets crystal pins analog input.
// RULE_10: Clock-mode bit 0 enables reset pin.
// RULE_11: Clock-mode bit 1 clear stops watchdog.
// RULE_12: Watchdog stops when low RC off; with fast wake-up on it keeps counting on the system clock.
// RULE_13: Watchdog runs through halts, resets chip.
// RULE_14: Watchdog clock: low RC or system.
// RULE_15: Software orders watchdog and fast wake-up.
// RULE_16: Full halt stops clocks and oscillators; low RC stays on while it and the watchdog are enabled.
// RULE_17: Processor halt gates core, oscillators run.
// RULE_18: Source change is glitch-free, core gated.
module osc_clock_switch_watchdog #(
  parameter int WDT_LIMIT = osc_clock_pkg::WDT_LIMIT_DEF
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Core halt and wake events
  input  wire logic        halt_sys,
  input  wire logic        halt_exe,
  input  wire logic        wake_event,
  // Pins and oscillator status
  input  wire logic        port_a_bit5,
  input  wire logic        low_rc_osc_clk,
  input  wire logic        crystal_osc_ok,
  // Oscillator and clock control
  output logic             low_rc_osc_en,
  output logic             high_rc_osc_en,
  output logic             crystal_osc_en,
  output logic [1:0]       crystal_range,
  output logic [1:0]       sys_src,
  output logic [2:0]       sys_sel,
  output logic             core_clk_en,
  // Reset requests
  output logic             ext_reset_req,
  output logic             wdt_reset_req
);
  // Whole-module state
  typedef struct packed {
    logic [7:0]  clock_mode_reg;       // Software clock-mode register
    logic [7:0]  crystal_osc_ctrl_reg; // Crystal control register
    logic        fast_wake;            // Fast wake-up enable
    logic        wr_pend;              // Write data phase pending
    logic [7:0]  wr_addr;              // Captured write offset
    logic [31:0] rdata;                // Read data for the data phase
    logic        ready;                // Slave ready
    logic [1:0]  rst_sync;             // Reset pin synchroniser
    logic [2:0]  lrc_sync;             // Low RC clock sync plus edge stage
    logic [1:0]  xok_sync;             // Crystal-ok synchroniser
    osc_clock_pkg::sw_type   sw;       // Switch sequencer
    osc_clock_pkg::src_type  cur_src;  // Source driving the core
    osc_clock_pkg::src_type  new_src;  // Source being switched to
    osc_clock_pkg::halt_type halt;     // Halt mode
    logic        wdt_restart;          // Watchdog restart pulse
    logic        core_en;              // Core clock gate
    logic        lrc_en;               // Low RC enable out
    logic        hrc_en;               // High RC enable out
    logic        xtal_en;              // Crystal enable out
    logic        ext_rst;              // Reset pin request
  } top_state_type;

  top_state_type st_ff;
  top_state_type nxt_st;
  logic          wdt_tick;     // Watchdog tick this cycle
  logic          wdt_run;      // Watchdog may count
  logic          wdt_timeout;  // Watchdog expiry pulse
  logic          addr_phase;   // Valid address phase
  logic          old_running;  // Outgoing source oscillates
  logic          new_running;  // Incoming source oscillates

  // Map a select field to its source
  function automatic osc_clock_pkg::src_type src_of(input logic [2:0] sel);
    osc_clock_pkg::src_type s;
    s = osc_clock_pkg::SRC_HIGH_RC;
    if (sel == osc_clock_pkg::SEL_CRYSTAL) begin
      s = osc_clock_pkg::SRC_CRYSTAL;
    end else if (sel == osc_clock_pkg::SEL_LOW_A || sel == osc_clock_pkg::SEL_LOW_B
                 || sel == osc_clock_pkg::SEL_LOW_C) begin
      s = osc_clock_pkg::SRC_LOW_RC;
    end
    return s;
  endfunction

  // Whether a source oscillates under the current register settings
  function automatic logic running(input osc_clock_pkg::src_type s, input top_state_type t);
    logic r;
    case (s)
      osc_clock_pkg::SRC_LOW_RC:  r = t.clock_mode_reg[osc_clock_pkg::CM_LOW_RC_BIT];
      osc_clock_pkg::SRC_HIGH_RC: r = t.clock_mode_reg[osc_clock_pkg::CM_HIGH_RC_BIT];
      // RULE_05 no settle check
      osc_clock_pkg::SRC_CRYSTAL: r = t.crystal_osc_ctrl_reg[osc_clock_pkg::XT_EN_BIT]
                                      && t.xok_sync[1];
      default:                    r = 1'b0;
    endcase
    return r;
  endfunction

  assign addr_phase  = hsel && htrans[1] && hready;
  assign old_running = running(st_ff.cur_src, st_ff);
  assign new_running = running(st_ff.new_src, st_ff);

  // Watchdog source and gating
  always_comb begin
    // RULE_14 source by wake mode
    wdt_tick = st_ff.fast_wake ? 1'b1 : (st_ff.lrc_sync[1] && !st_ff.lrc_sync[2]);
    // RULE_11 RULE_12 watchdog gating
    wdt_run  = st_ff.clock_mode_reg[osc_clock_pkg::CM_WDT_EN_BIT]
               && (st_ff.fast_wake || st_ff.clock_mode_reg[osc_clock_pkg::CM_LOW_RC_BIT]);
  end

  // Next-state logic for bus, registers, switch and halts
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wdt_restart = 1'b0;
    nxt_st.ready = 1'b1;
    // Synchronisers: first stage only feeds the second
    nxt_st.rst_sync = {st_ff.rst_sync[0], port_a_bit5};
    nxt_st.lrc_sync = {st_ff.lrc_sync[1:0], low_rc_osc_clk};
    nxt_st.xok_sync = {st_ff.xok_sync[0], crystal_osc_ok};

    // Write data phase
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        // RULE_02 RULE_03 mode write
        osc_clock_pkg::OFF_CLOCK_MODE:   nxt_st.clock_mode_reg = hwdata[7:0];
        // RULE_07 RULE_08 crystal control
        osc_clock_pkg::OFF_CRYSTAL_CTRL: nxt_st.crystal_osc_ctrl_reg = hwdata[7:0];
        osc_clock_pkg::OFF_MISC: begin
          nxt_st.fast_wake = hwdata[osc_clock_pkg::MISC_FAST_WAKE_BIT];
        end
        osc_clock_pkg::OFF_COMMAND: begin
          nxt_st.wdt_restart = hwdata[osc_clock_pkg::CMD_WDT_RESTART_BIT];
        end
        default: ; // Unmapped or read-only: ignored
      endcase
    end

    // Address phase: capture writes, prepare reads
    nxt_st.wr_pend = addr_phase && hwrite;
    if (addr_phase) begin
      nxt_st.wr_addr = haddr[7:0];
    end
    nxt_st.rdata = 32'h0;
    if (addr_phase && !hwrite && haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        osc_clock_pkg::OFF_CLOCK_MODE:   nxt_st.rdata[7:0] = st_ff.clock_mode_reg;
        osc_clock_pkg::OFF_CRYSTAL_CTRL: nxt_st.rdata[7:0] = st_ff.crystal_osc_ctrl_reg;
        osc_clock_pkg::OFF_MISC:         nxt_st.rdata[0] = st_ff.fast_wake;
        osc_clock_pkg::OFF_STATUS: begin
          nxt_st.rdata[3:0] = st_ff.sw;
          nxt_st.rdata[5:4] = st_ff.cur_src;
          nxt_st.rdata[7:6] = st_ff.halt;
          nxt_st.rdata[8]   = st_ff.xok_sync[1];
        end
        default: ; // Unmapped reads return zero
      endcase
    end

    // Switch sequencer
    case (st_ff.sw)
      osc_clock_pkg::SW_IDLE: begin
        // RULE_18 start glitch-free switch
        if (src_of(st_ff.clock_mode_reg[7:5]) != st_ff.cur_src) begin
          nxt_st.new_src = src_of(st_ff.clock_mode_reg[7:5]);
          nxt_st.sw      = osc_clock_pkg::SW_OLD;
        end
      end
      osc_clock_pkg::SW_OLD: begin
        // RULE_04 old source gone hangs
        if (old_running) begin
          nxt_st.sw = osc_clock_pkg::SW_NEW;
        end else begin
          nxt_st.sw = osc_clock_pkg::SW_HUNG;
        end
      end
      osc_clock_pkg::SW_NEW: begin
        // RULE_05 unstable crystal hangs
        if (new_running) begin
          nxt_st.cur_src = st_ff.new_src;
          nxt_st.sw      = osc_clock_pkg::SW_IDLE;
        end else begin
          nxt_st.sw = osc_clock_pkg::SW_HUNG;
        end
      end
      osc_clock_pkg::SW_HUNG: ; // Only a reset leaves this state
      default: nxt_st.sw = osc_clock_pkg::SW_HUNG;
    endcase

    // Halt entry and wake; halt wins over wake in one cycle
    if (halt_sys) begin
      nxt_st.halt = osc_clock_pkg::HALT_SYS;
    end else if (halt_exe) begin
      nxt_st.halt = osc_clock_pkg::HALT_EXE;
    end else if (wake_event) begin
      nxt_st.halt = osc_clock_pkg::HALT_NONE;
    end

    // Core clock gate: off while switching, hung or halted
    // RULE_17 RULE_18 core gating
    nxt_st.core_en = nxt_st.sw == osc_clock_pkg::SW_IDLE
                     && nxt_st.halt == osc_clock_pkg::HALT_NONE;

    // Oscillator enables; full halt stops them, low RC kept only for watchdog
    // RULE_16 full halt stops oscillators
    if (nxt_st.halt == osc_clock_pkg::HALT_SYS) begin
      nxt_st.hrc_en  = 1'b0;
      nxt_st.xtal_en = 1'b0;
      nxt_st.lrc_en  = nxt_st.clock_mode_reg[osc_clock_pkg::CM_LOW_RC_BIT]
                       && nxt_st.clock_mode_reg[osc_clock_pkg::CM_WDT_EN_BIT];
    end else begin
      nxt_st.hrc_en  = nxt_st.clock_mode_reg[osc_clock_pkg::CM_HIGH_RC_BIT];
      nxt_st.xtal_en = nxt_st.crystal_osc_ctrl_reg[osc_clock_pkg::XT_EN_BIT];
      nxt_st.lrc_en  = nxt_st.clock_mode_reg[osc_clock_pkg::CM_LOW_RC_BIT];
    end

    // RULE_10 reset pin, no pull-up
    nxt_st.ext_rst = st_ff.clock_mode_reg[osc_clock_pkg::CM_RESET_PIN_BIT]
                     && !st_ff.rst_sync[1];
  end

  // Register everything; clock enable freezes all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff                      <= '0;
      st_ff.clock_mode_reg       <= osc_clock_pkg::CLOCK_MODE_RST;
      st_ff.crystal_osc_ctrl_reg <= osc_clock_pkg::CRYSTAL_CTRL_RST;
      st_ff.sw                   <= osc_clock_pkg::SW_IDLE;
      st_ff.cur_src              <= osc_clock_pkg::SRC_LOW_RC;
      st_ff.new_src              <= osc_clock_pkg::SRC_LOW_RC;
      st_ff.halt                 <= osc_clock_pkg::HALT_NONE;
      st_ff.ready                <= 1'b1;
      st_ff.core_en              <= 1'b1;
      st_ff.lrc_en               <= 1'b1;
      st_ff.hrc_en               <= 1'b1;
      st_ff.rst_sync             <= 2'h3;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Watchdog counter
  osc_watchdog #(
    .LIMIT (WDT_LIMIT)
  ) u_wdt (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .run        (wdt_run),
    .tick       (wdt_tick),
    .restart    (st_ff.wdt_restart),
    .timeout_ff (wdt_timeout)
  );

  // Outputs, all from flip-flops except hresp, tied low
  assign hreadyout      = st_ff.ready;
  assign hresp          = 1'b0;
  assign hrdata         = st_ff.rdata;
  assign low_rc_osc_en  = st_ff.lrc_en;
  assign high_rc_osc_en = st_ff.hrc_en;
  assign crystal_osc_en = st_ff.xtal_en;
  assign crystal_range  = st_ff.crystal_osc_ctrl_reg[osc_clock_pkg::XT_RANGE_LSB +: 2];
  assign sys_src        = st_ff.cur_src;
  assign sys_sel        = st_ff.clock_mode_reg[osc_clock_pkg::CM_SEL_LSB +: 3];
  assign core_clk_en    = st_ff.core_en;
  assign ext_reset_req  = st_ff.ext_rst;
  assign wdt_reset_req  = wdt_timeout;

  a_dead_old_hangs: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    ce && st_ff.sw == osc_clock_pkg::SW_OLD && !old_running
    |=> st_ff.sw == osc_clock_pkg::SW_HUNG ##1 !core_clk_en)
    else $error("dead outgoing source did not hang the switch");

  a_unstable_xtal: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    ce && st_ff.sw == osc_clock_pkg::SW_NEW && !new_running
    |=> st_ff.sw == osc_clock_pkg::SW_HUNG)
    else $error("unstable new source did not hang");

  a_switch_gated: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
    st_ff.sw != osc_clock_pkg::SW_IDLE |-> !core_clk_en)
    else $error("core clock enabled during a source switch");

  a_pin_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    ce && st_ff.clock_mode_reg[osc_clock_pkg::CM_RESET_PIN_BIT] && !st_ff.rst_sync[1]
    |=> ext_reset_req)
    else $error("reset pin low not forwarded");

  a_sys_halt_stops: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
    ce && halt_sys |=> !core_clk_en && !high_rc_osc_en && !crystal_osc_en)
    else $error("full halt left clocks running");

  a_exe_halt_keeps: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    st_ff.halt == osc_clock_pkg::HALT_EXE
    |-> !core_clk_en && high_rc_osc_en == st_ff.clock_mode_reg[osc_clock_pkg::CM_HIGH_RC_BIT])
    else $error("processor halt disturbed oscillators");

  a_fast_wake_src: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
    st_ff.fast_wake && st_ff.clock_mode_reg[osc_clock_pkg::CM_WDT_EN_BIT] |-> wdt_tick && wdt_run)
    else $error("fast wake-up watchdog not on system clock");

  a_xtal_write: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    ce && st_ff.wr_pend && st_ff.wr_addr == osc_clock_pkg::OFF_CRYSTAL_CTRL && !halt_sys
    && st_ff.halt != osc_clock_pkg::HALT_SYS
    |=> crystal_range == $past(hwdata[6:5]) && crystal_osc_en == $past(hwdata[7]))
    else $error("crystal control write not applied");
endmodule // osc_clock_switch_watchdog

// *** shared/osc_clock_pkg.sv ***
// Constants and types shared by the oscillator, clock-switch and watchdog logic
package osc_clock_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CLOCK_MODE   = 8'h00;
  localparam logic [7:0] OFF_CRYSTAL_CTRL = 8'h04;
  localparam logic [7:0] OFF_MISC         = 8'h08;
  localparam logic [7:0] OFF_STATUS       = 8'h0c;
  localparam logic [7:0] OFF_COMMAND      = 8'h10;
  // Reset values
  localparam logic [7:0] CLOCK_MODE_RST   = 8'hf6;
  localparam logic [7:0] CRYSTAL_CTRL_RST = 8'h00;
  // Clock-mode field positions
  localparam int CM_RESET_PIN_BIT = 0;
  localparam int CM_WDT_EN_BIT    = 1;
  localparam int CM_LOW_RC_BIT    = 2;
  localparam int CM_HIGH_RC_BIT   = 4;
  localparam int CM_SEL_LSB       = 5;
  // Crystal control field positions
  localparam int XT_RANGE_LSB = 5;
  localparam int XT_EN_BIT    = 7;
  // Misc and command bits
  localparam int MISC_FAST_WAKE_BIT = 0;
  localparam int CMD_WDT_RESTART_BIT = 0;
  // Source select codes in the clock-mode select field
  localparam logic [2:0] SEL_CRYSTAL = 3'h5;
  localparam logic [2:0] SEL_LOW_A   = 3'h0;
  localparam logic [2:0] SEL_LOW_B   = 3'h6;
  localparam logic [2:0] SEL_LOW_C   = 3'h7;
  // Watchdog timeout in ticks
  localparam int WDT_LIMIT_DEF = 256;
  // Clock sources
  typedef enum logic [1:0] {
    SRC_LOW_RC  = 2'h0,
    SRC_HIGH_RC = 2'h1,
    SRC_CRYSTAL = 2'h2
  } src_type;
  // Glitch-free switch sequencer, one-hot
  typedef enum logic [3:0] {
    SW_IDLE = 4'h1,
    SW_OLD  = 4'h2,
    SW_NEW  = 4'h4,
    SW_HUNG = 4'h8
  } sw_type;
  // Halt modes
  typedef enum logic [1:0] {
    HALT_NONE = 2'h0,
    HALT_EXE  = 2'h1,
    HALT_SYS  = 2'h2
  } halt_type;
endpackage

// *** logic/osc_watchdog.sv ***
// Watchdog counter with restart and one-cycle timeout pulse
module osc_watchdog #(
  parameter int LIMIT = osc_clock_pkg::WDT_LIMIT_DEF,
  parameter int CW    = 16
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // Control
  input  wire logic run,
  input  wire logic tick,
  input  wire logic restart,
  // Result
  output logic      timeout_ff
);
  // Refuse limits the counter cannot hold
  if (LIMIT < 2 || LIMIT >= (1 << CW)) begin : g_bad_limit
    $error("watchdog limit out of range");
  end

  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  // All state of the counter
  typedef struct packed {
    logic [CW-1:0] count;   // Ticks since last restart or expiry
    logic          timeout; // Expiry pulse
  } wdt_state_type;

  wdt_state_type st_ff;
  wdt_state_type nxt_st;

  // Count ticks while running; halts do not stop it
  always_comb begin
    nxt_st = st_ff;
    nxt_st.timeout = 1'b0;
    if (restart) begin
      nxt_st.count = '0;
    // RULE_13 counts through halts
    end else if (run && tick) begin
      if (st_ff.count == LAST) begin
        nxt_st.count   = '0;
        nxt_st.timeout = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 1'b1;
      end
    end
  end

  // Register the state; clock enable freezes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign timeout_ff = st_ff.timeout;

  a_wdt_expiry: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
    ce && run && tick && !restart && st_ff.count == LAST |=> timeout_ff)
    else $error("watchdog did not expire at its limit");

  a_wdt_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    ce && !run && !restart |=> $stable(st_ff.count))
    else $error("stopped watchdog kept counting");
endmodule // osc_watchdog

// *** sim/crystal_resonator_model.sv ***
// Behavioural crystal resonator: start-up delay, then oscillation established
module crystal_resonator_model #(
  parameter int START_CYCLES = 40  // Start-up time in system clock cycles
) (
  // Clock
  input  wire logic       hclk,
  // Drive from the device
  input  wire logic       crystal_osc_en,
  input  wire logic [1:0] crystal_range,
  // Oscillation status
  output logic            crystal_osc_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  int start_cnt = 0;  // Cycles since drive began, held at START_CYCLES

  // range zero never oscillates
  // Undriven or unranged crystal never settles, so a bad switch is caught
  always @(posedge hclk) begin
    if (crystal_osc_en !== 1'b1 || crystal_range === 2'h0) begin
      start_cnt <= 0;
      crystal_osc_ok <= 1'b0;
    end else begin
      if (start_cnt < START_CYCLES) start_cnt <= start_cnt + 1;
      crystal_osc_ok <= (start_cnt >= START_CYCLES);
    end
  end

  initial crystal_osc_ok = 1'b0;
endmodule  // crystal_resonator_model

// *** sim/tb_osc_clock_switch_watchdog.sv ***
// Self-checking bench for clock switching, crystal, halts, reset pin and watchdog
module tb_osc_clock_switch_watchdog;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WDT_LIM = 4;      // Short watchdog count for simulation
  localparam int TMO     = 20000;  // Cycle ceiling, tests need far fewer

  // Bus and control drive
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        halt_sys = 1'b0;
  logic        halt_exe = 1'b0;
  logic        wake_event = 1'b0;
  logic        port_a_bit5 = 1'b1;
  logic        low_rc_osc_clk = 1'b0;
  // Design outputs
  logic        hreadyout, hresp, crystal_osc_ok;
  logic [31:0] hrdata, rd;
  logic        low_rc_osc_en, high_rc_osc_en, crystal_osc_en, core_clk_en;
  logic        ext_reset_req, wdt_reset_req;
  logic [1:0]  crystal_range, sys_src;
  logic [2:0]  sys_sel;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          wdt_pulses = 0;
  int          got;

  always #4 hclk = ~hclk;
  // Low RC runs unrelated to hclk and stands still while disabled
  always begin
    #37;
    low_rc_osc_clk = (low_rc_osc_en === 1'b1) ? ~low_rc_osc_clk : 1'b0;
  end

  osc_clock_switch_watchdog #(.WDT_LIMIT(WDT_LIM)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .halt_sys(halt_sys), .halt_exe(halt_exe), .wake_event(wake_event),
    .port_a_bit5(port_a_bit5), .low_rc_osc_clk(low_rc_osc_clk),
    .crystal_osc_ok(crystal_osc_ok), .low_rc_osc_en(low_rc_osc_en),
    .high_rc_osc_en(high_rc_osc_en), .crystal_osc_en(crystal_osc_en),
    .crystal_range(crystal_range), .sys_src(sys_src), .sys_sel(sys_sel),
    .core_clk_en(core_clk_en), .ext_reset_req(ext_reset_req),
    .wdt_reset_req(wdt_reset_req));

  crystal_resonator_model #(.START_CYCLES(40)) i_xtal (
    .hclk(hclk), .crystal_osc_en(crystal_osc_en), .crystal_range(crystal_range),
    .crystal_osc_ok(crystal_osc_ok));

  // Watchdog pulse tally and hang guard
  always @(posedge hclk) begin
    if (wdt_reset_req === 1'b1) wdt_pulses++;
    cycles++;
    if (cycles == TMO) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Register read results
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH reg t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Output pins and derived flags
  task automatic chk_sig(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH sig t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One single AHB-Lite transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk_reg(rd, e);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // Count watchdog pulses over a window of cycles
  task automatic wdt_window(input int n);
    wdt_pulses = 0;
    repeat (n) @(posedge hclk);
    got = wdt_pulses;
  endtask

  task automatic halt_pulse(input logic full);
    if (full) halt_sys <= 1'b1;
    else halt_exe <= 1'b1;
    @(posedge hclk);
    halt_sys <= 1'b0;
    halt_exe <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic wake();
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  initial begin
    do_reset();
    rdr(osc_clock_pkg::OFF_CLOCK_MODE, 32'hf6);
    rdr(osc_clock_pkg::OFF_CRYSTAL_CTRL, 32'h0);
    rdr(osc_clock_pkg::OFF_STATUS, 32'h001);
    chk_sig({high_rc_osc_en, low_rc_osc_en, crystal_osc_en, core_clk_en}, 8'h0d);
    // Unmapped place reads zero and ignores writes
    ahb(1'b1, 8'h20, 32'hff);
    rdr(8'h20, 32'h0);
    $display("test reset_and_map done");

    // Switch to high RC with low RC kept, then drop low RC
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'h36);
    // Gate drops one edge after the write lands; look once it has settled
    repeat (2) @(posedge hclk);
    chk_sig({7'h0, core_clk_en}, 8'h0);
    repeat (5) @(posedge hclk);
    chk_sig({4'h0, sys_src, core_clk_en, low_rc_osc_en}, 8'h07);
    rdr(osc_clock_pkg::OFF_STATUS, 32'h011);
    // old oscillator dropped only after the switch
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'h32);
    repeat (6) @(posedge hclk);
    chk_sig({4'h0, sys_src, high_rc_osc_en, low_rc_osc_en}, 8'h06);
    wdt_window(60);
    chk_sig(8'(got), 8'h0);
    ahb(1'b1, osc_clock_pkg::OFF_MISC, 32'h1);
    wdt_window(40);
    chk_sig({7'h0, got >= 7 && got <= 10}, 8'h1);
    // Restart command every transfer keeps the watchdog from expiring
    repeat (2) ahb(1'b1, osc_clock_pkg::OFF_COMMAND, 32'h1);
    wdt_pulses = 0;
    repeat (10) ahb(1'b1, osc_clock_pkg::OFF_COMMAND, 32'h1);
    chk_sig(8'(wdt_pulses), 8'h0);
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'h30);
    repeat (4) @(posedge hclk);
    wdt_window(60);
    chk_sig(8'(got), 8'h0);
    $display("test high_rc_switch done");

    // Switching and killing the old source at once hangs
    do_reset();
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'h50);
    repeat (8) @(posedge hclk);
    chk_sig({5'h0, sys_src, core_clk_en}, 8'h0);
    rdr(osc_clock_pkg::OFF_STATUS, 32'h008);
    $display("test hang_on_kill done");

    // Crystal selected without oscillation hangs
    do_reset();
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'ha6);
    repeat (8) @(posedge hclk);
    rdr(osc_clock_pkg::OFF_STATUS, 32'h008);
    $display("test hang_no_crystal done");

    // Drive ranges 1 to 3, then a proper crystal switch
    do_reset();
    for (int r = 1; r <= 3; r++) begin
      ahb(1'b1, osc_clock_pkg::OFF_CRYSTAL_CTRL, {24'h0, 1'b1, 2'(r), 5'h0});
      repeat (2) @(posedge hclk);
      chk_sig({5'h0, crystal_osc_en, crystal_range}, 8'(4 + r));
    end
    rdr(osc_clock_pkg::OFF_CRYSTAL_CTRL, 32'he0);
    // wait for oscillation before selecting the crystal
    for (int i = 0; i < 100 && rd[8] !== 1'b1; i++) ahb(1'b0, osc_clock_pkg::OFF_STATUS, 0);
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'ha6);
    repeat (6) @(posedge hclk);
    chk_sig({3'h0, sys_sel, sys_src}, 8'h16);
    rdr(osc_clock_pkg::OFF_STATUS, 32'h121);
    // low RC dropped only once the crystal drives the core
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'ha2);
    repeat (6) @(posedge hclk);
    chk_sig({4'h0, sys_src, core_clk_en, low_rc_osc_en}, 8'h0a);
    $display("test crystal_switch done");

    // Halts with watchdog on system clock
    ahb(1'b1, osc_clock_pkg::OFF_MISC, 32'h1);
    halt_pulse(1'b0);
    chk_sig({6'h0, core_clk_en, crystal_osc_en}, 8'h01);
    wdt_window(40);
    chk_sig({7'h0, got > 0}, 8'h1);
    wake();
    chk_sig({7'h0, core_clk_en}, 8'h1);
    // watchdog off, fast wake-up still on, before a full halt
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'ha0);
    halt_pulse(1'b1);
    chk_sig({5'h0, core_clk_en, crystal_osc_en, high_rc_osc_en}, 8'h0);
    ahb(1'b0, osc_clock_pkg::OFF_STATUS, 32'h0);
    chk_reg(rd & 32'hc0, 32'h80);
    wake();
    chk_sig({7'h0, core_clk_en}, 8'h1);
    // fast wake-up off first, then watchdog back on
    ahb(1'b1, osc_clock_pkg::OFF_MISC, 32'h0);
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'ha2);
    wdt_window(40);
    chk_sig(8'(got), 8'h0);
    $display("test halts done");

    // Reset pin only acts when enabled
    do_reset();
    port_a_bit5 <= 1'b0;
    repeat (10) @(posedge hclk);
    chk_sig({7'h0, ext_reset_req}, 8'h0);
    ahb(1'b1, osc_clock_pkg::OFF_CLOCK_MODE, 32'hf7);
    repeat (6) @(posedge hclk);
    chk_sig({7'h0, ext_reset_req}, 8'h1);
    // Clock enable low freezes the request despite the pin going high
    ce <= 1'b0;
    port_a_bit5 <= 1'b1;
    repeat (6) @(posedge hclk);
    chk_sig({7'h0, ext_reset_req}, 8'h1);
    ce <= 1'b1;
    repeat (6) @(posedge hclk);
    chk_sig({7'h0, ext_reset_req}, 8'h0);
    $display("test reset_pin done");
    close_out();
  end
endmodule  // tb_osc_clock_switch_watchdog
